// ### inc/bfls_pkg.sv
// Shared constants and types for the bit, flag and load/store execution unit.
// Assumes a 32-bit APB master and an internal byte-wide data memory.
`default_nettype none

package bfls_pkg;

  // ==========================================================
  // Register map (byte offsets)
  localparam int APB_AW = 8;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR_K = 8'h04;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_STATE = 8'h0c;
  localparam logic [7:0] OFS_GPR_SEL = 8'h10;
  localparam logic [7:0] OFS_GPR_DATA = 8'h14;

  // ==========================================================
  // Command word fields
  localparam int F_OP_LSB = 0;
  localparam int F_OP_W = 5;
  localparam int F_MODE_LSB = 5;
  localparam int F_PTR_LSB = 7;
  localparam int F_DST_LSB = 9;
  localparam int F_SRC_LSB = 14;
  localparam int F_BIT_LSB = 19;
  localparam int F_IMM_LSB = 22;
  localparam int DISP_W = 6;

  // ==========================================================
  // Sizes and reset values
  localparam int GPR_N = 32;
  localparam int DMEM_AW = 16;
  localparam int DMEM_DEPTH = 256;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] GPR_RST = 8'h00;

  // ==========================================================
  // Status flag positions
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ==========================================================
  // Pointer pairs: code and low register index
  localparam logic [1:0] PTR_X = 2'h0;
  localparam logic [1:0] PTR_Y = 2'h1;
  localparam logic [1:0] PTR_Z = 2'h2;
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_ROTATE_RIGHT_CARRY,
    OP_ARITH_SHIFT_RIGHT,
    OP_NIBBLE_SWAP,
    OP_INDEXED_FLAG_SET,
    OP_INDEXED_FLAG_CLEAR,
    OP_COPY_BIT_TO_TRANSFER_FLAG,
    OP_COPY_TRANSFER_FLAG_TO_BIT,
    OP_REGISTER_COPY,
    OP_REGISTER_PAIR_COPY,
    OP_IMMEDIATE_LOAD,
    OP_FETCH_VIA_POINTER,
    OP_FETCH_POINTER_OFFSET,
    OP_FETCH_ABSOLUTE,
    OP_WRITE_VIA_POINTER
  } bfls_op_type;

  typedef enum logic [1:0] {
    PM_PLAIN,
    PM_POST_INC,
    PM_PRE_DEC
  } bfls_pmode_type;

  typedef enum logic {
    BFLS_IDLE,
    BFLS_MEM
  } bfls_state_type;

endpackage

`default_nettype wire

// ### inc/bfls_dmem_if.sv
// Data memory port between the execution unit and its byte memory.
// Assumes write on the clock edge and combinational read.
`default_nettype none

interface bfls_dmem_if;
  import bfls_pkg::*;
  logic [DMEM_AW-1:0] addr;
  logic we;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport master (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface

`default_nettype wire

// ### verilog/bfls_dmem.sv
// Byte-wide internal data memory.
// Assumes the address is held stable for the whole access cycle.
`default_nettype none

module bfls_dmem #(
  parameter int DEPTH = bfls_pkg::DMEM_DEPTH
) (
  // Clock
  input wire logic clk,
  // Memory port
  bfls_dmem_if.mem port
);
  import bfls_pkg::*;

  localparam int IW = $clog2(DEPTH);

  logic [7:0] mem_array [DEPTH];

  // Upper address bits wrap onto the array
  always_ff @(posedge clk)
  begin
    if (port.we)
    begin
      mem_array[port.addr[IW-1:0]] <= port.wdata;
    end
  end

  assign port.rdata = mem_array[port.addr[IW-1:0]];

endmodule

`default_nettype wire

// ### verilog/bfls_exec.sv
// Execution unit for shifts, bit transfers, flag ops, moves and data loads/stores.
// Assumes an APB master on pclk and holds its own data memory instance.
//
// What this block does
// RULE1: rotate right through carry: carry to bit 7, bit 0 to carry; Z,C,N,V.
// RULE2: arithmetic right shift keeps bit 7, bit 0 to carry; Z,C,N,V; one cycle.
// RULE3: copy chosen source bit into transfer flag; other flags kept; one cycle.
// RULE4: copy transfer flag into chosen destination bit; flags kept; one cycle.
// RULE5: each named or indexed flag set forces that bit to one in one cycle.
// RULE6: each named or indexed flag clear forces that bit to zero in one cycle.
// RULE7: single flag set or clear touches only that flag, no general register.
// RULE8: load with post-increment reads at pointer, then pointer plus one; two cycles.
// RULE9: load with pre-decrement lowers pointer first, reads new address; two cycles.
// RULE10: offset load from second or third pointer plus displacement; pointer kept.
// RULE11: absolute load reads byte at address held in addr_k_reg, written before the command; two cycles.
// RULE12: store with post-increment writes at pointer, then pointer plus one.
// RULE13: store with pre-decrement lowers pointer first, writes new address.
// RULE14: nibble swap exchanges register halves in one cycle; flags kept.
// RULE15: register copy, pair copy and immediate load take one cycle; flags kept.
// RULE16: plain pointer load and store keep pointer; two cycles; flags kept.
`default_nettype none

module bfls_exec (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [bfls_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import bfls_pkg::*;

  // ==========================================================
  // State
  logic [7:0] gpr [GPR_N];
  logic [7:0] flags_reg;
  logic [31:0] cmd_reg;
  logic [DMEM_AW-1:0] addr_k_reg;
  logic [4:0] gpr_sel_reg;
  bfls_state_type state_reg;
  logic [DMEM_AW-1:0] mem_addr_reg;
  logic mem_store_reg;
  logic [7:0] mem_wdata_reg;
  logic [4:0] mem_dst_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  bfls_dmem_if dmem ();

  bfls_dmem u_dmem (
    .clk (pclk),
    .port (dmem.mem)
  );

  assign dmem.addr = mem_addr_reg;
  assign dmem.we = mem_store_reg && (state_reg == BFLS_MEM);
  assign dmem.wdata = mem_wdata_reg;

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ==========================================================
  // Helpers
  function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
    logic [4:0] idx;
    idx = PTR_X_LO;
    if (sel == PTR_Y)
      idx = PTR_Y_LO;
    else if (sel == PTR_Z)
      idx = PTR_Z_LO;
    return idx;
  endfunction

  function automatic logic [15:0] ptr_pair(input logic [1:0] sel);
    logic [4:0] lo;
    lo = ptr_lo(sel);
    return {gpr[{lo[4:1], 1'b1}], gpr[lo]};
  endfunction

  function automatic logic [7:0] shift_flags(input logic [7:0] f, input logic [7:0] res,
                                             input logic c);
    logic [7:0] o;
    o = f;
    o[FLAG_C] = c;
    o[FLAG_Z] = (res == 8'h00);
    o[FLAG_N] = res[7];
    o[FLAG_V] = res[7] ^ c;
    return o;
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    return (a == OFS_CMD) || (a == OFS_ADDR_K) || (a == OFS_FLAGS) || (a == OFS_STATE)
        || (a == OFS_GPR_SEL) || (a == OFS_GPR_DATA);
  endfunction

  // ==========================================================
  // APB access decode
  logic access;
  logic wr;
  logic cmd_go;

  // Accesses wait while a memory operation is in flight
  assign access = psel && penable && !pready_reg && (state_reg == BFLS_IDLE);
  assign wr = access && pwrite && reg_hit(paddr);
  assign cmd_go = wr && (paddr == OFS_CMD);

  // ==========================================================
  // Command decode and execution
  bfls_op_type c_op;
  bfls_pmode_type c_mode;
  logic [1:0] c_ptr;
  logic [4:0] c_dst;
  logic [4:0] c_src;
  logic [2:0] c_bit;
  logic [7:0] c_imm;
  logic [7:0] rd_v;
  logic [7:0] rs_v;
  logic [15:0] ptr_cur;

  assign c_op = bfls_op_type'(pwdata[F_OP_LSB +: F_OP_W]);
  assign c_mode = bfls_pmode_type'(pwdata[F_MODE_LSB +: 2]);
  assign c_ptr = pwdata[F_PTR_LSB +: 2];
  assign c_dst = pwdata[F_DST_LSB +: 5];
  assign c_src = pwdata[F_SRC_LSB +: 5];
  assign c_bit = pwdata[F_BIT_LSB +: 3];
  assign c_imm = pwdata[F_IMM_LSB +: 8];
  assign rd_v = gpr[c_dst];
  assign rs_v = gpr[c_src];
  // Function reads the register file, so a process keeps it in the sensitivity
  always_comb
  begin
    ptr_cur = ptr_pair(c_ptr);
  end

  logic x_we;
  logic x_pair;
  logic [4:0] x_wa;
  logic [7:0] x_wd;
  logic [7:0] x_wd_hi;
  logic p_we;
  logic [15:0] p_wd;
  logic [7:0] f_next;
  logic m_go;
  logic m_store;
  logic [DMEM_AW-1:0] m_addr;

  always_comb
  begin
    x_we = 1'b0;
    x_pair = 1'b0;
    x_wa = c_dst;
    x_wd = rd_v;
    x_wd_hi = 8'h00;
    p_we = 1'b0;
    p_wd = ptr_cur;
    f_next = flags_reg;
    m_go = 1'b0;
    m_store = 1'b0;
    m_addr = ptr_cur;
    if (cmd_go)
    begin
      unique case (c_op)
        OP_ROTATE_RIGHT_CARRY:
        begin
          x_we = 1'b1;
          x_wd = {flags_reg[FLAG_C], rd_v[7:1]}; // [RULE1]
          f_next = shift_flags(flags_reg, x_wd, rd_v[0]); // [RULE1]
        end
        OP_ARITH_SHIFT_RIGHT:
        begin
          x_we = 1'b1;
          x_wd = {rd_v[7], rd_v[7:1]}; // [RULE2]
          f_next = shift_flags(flags_reg, x_wd, rd_v[0]); // [RULE2]
        end
        OP_NIBBLE_SWAP:
        begin
          x_we = 1'b1;
          x_wd = {rd_v[3:0], rd_v[7:4]}; // [RULE14]
        end
        OP_INDEXED_FLAG_SET:
          f_next[c_bit] = 1'b1; // [RULE5] [RULE7]
        OP_INDEXED_FLAG_CLEAR:
          f_next[c_bit] = 1'b0; // [RULE6] [RULE7]
        OP_COPY_BIT_TO_TRANSFER_FLAG:
          f_next[FLAG_T] = rs_v[c_bit]; // [RULE3]
        OP_COPY_TRANSFER_FLAG_TO_BIT:
        begin
          x_we = 1'b1;
          x_wd[c_bit] = flags_reg[FLAG_T]; // [RULE4]
        end
        OP_REGISTER_COPY:
        begin
          x_we = 1'b1;
          x_wd = rs_v; // [RULE15]
        end
        OP_REGISTER_PAIR_COPY:
        begin
          x_we = 1'b1;
          x_pair = 1'b1;
          x_wa = {c_dst[4:1], 1'b0};
          x_wd = gpr[{c_src[4:1], 1'b0}]; // [RULE15]
          x_wd_hi = gpr[{c_src[4:1], 1'b1}];
        end
        OP_IMMEDIATE_LOAD:
        begin
          x_we = 1'b1;
          x_wd = c_imm; // [RULE15]
        end
        OP_FETCH_VIA_POINTER, OP_WRITE_VIA_POINTER:
        begin
          m_go = (c_ptr != 2'h3);
          m_store = (c_op == OP_WRITE_VIA_POINTER);
          unique case (c_mode)
            PM_PLAIN: p_we = 1'b0; // [RULE16]
            PM_POST_INC:
            begin
              p_we = m_go;
              p_wd = ptr_cur + 16'h0001; // [RULE8] [RULE12]
            end
            PM_PRE_DEC:
            begin
              p_we = m_go;
              p_wd = ptr_cur - 16'h0001; // [RULE9] [RULE13]
              m_addr = p_wd;
            end
            default: m_go = 1'b0;
          endcase
        end
        OP_FETCH_POINTER_OFFSET:
        begin
          m_go = (c_ptr == PTR_Y) || (c_ptr == PTR_Z); // [RULE10]
          m_addr = ptr_cur + {{(DMEM_AW-DISP_W){1'b0}}, c_imm[DISP_W-1:0]}; // [RULE10]
        end
        OP_FETCH_ABSOLUTE:
        begin
          m_go = 1'b1;
          m_addr = addr_k_reg; // [RULE11]
        end
        default: x_we = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // General registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < GPR_N; i++)
      begin
        gpr[i] <= GPR_RST;
      end
    end
    else
    begin
      if (x_we)
        gpr[x_wa] <= x_wd;
      if (x_pair)
        gpr[{x_wa[4:1], 1'b1}] <= x_wd_hi;
      if (p_we)
        {gpr[{ptr_lo(c_ptr)}+5'h01], gpr[ptr_lo(c_ptr)]} <= p_wd; // [RULE8] [RULE9]
      if (state_reg == BFLS_MEM && !mem_store_reg)
        gpr[mem_dst_reg] <= dmem.rdata; // [RULE8] [RULE11]
      if (wr && paddr == OFS_GPR_DATA)
        gpr[gpr_sel_reg] <= pwdata[7:0];
    end
  end

  // ==========================================================
  // Status flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_reg <= FLAGS_RST;
    else if (wr && paddr == OFS_FLAGS)
      flags_reg <= pwdata[7:0];
    else
      flags_reg <= f_next;
  end

  // ==========================================================
  // Memory sequencer: issue at command edge, finish one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= BFLS_IDLE;
      mem_addr_reg <= '0;
      mem_store_reg <= 1'b0;
      mem_wdata_reg <= 8'h00;
      mem_dst_reg <= 5'h00;
    end
    else
    begin
      unique case (state_reg)
        BFLS_IDLE:
          if (m_go)
          begin
            state_reg <= BFLS_MEM;
            mem_addr_reg <= m_addr;
            mem_store_reg <= m_store;
            mem_wdata_reg <= gpr[c_src];
            mem_dst_reg <= c_dst;
          end
        BFLS_MEM:
        begin
          state_reg <= BFLS_IDLE; // [RULE8] [RULE12]
          mem_store_reg <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // Software registers and APB answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_reg <= 32'h0000_0000;
      addr_k_reg <= '0;
      gpr_sel_reg <= 5'h00;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= access;
      pslverr_reg <= access && !reg_hit(paddr);
      prdata_reg <= 32'h0000_0000;
      if (wr)
      begin
        unique case (paddr)
          OFS_CMD: cmd_reg <= pwdata;
          OFS_ADDR_K: addr_k_reg <= pwdata[DMEM_AW-1:0];
          OFS_GPR_SEL: gpr_sel_reg <= pwdata[4:0];
          default: cmd_reg <= cmd_reg;
        endcase
      end
      if (access && !pwrite)
      begin
        unique case (paddr)
          OFS_CMD: prdata_reg <= cmd_reg;
          OFS_ADDR_K: prdata_reg <= {{(32-DMEM_AW){1'b0}}, addr_k_reg};
          OFS_FLAGS: prdata_reg <= {24'h00_0000, flags_reg};
          OFS_STATE: prdata_reg <= {31'h0000_0000, state_reg == BFLS_MEM};
          OFS_GPR_SEL: prdata_reg <= {27'h000_0000, gpr_sel_reg};
          OFS_GPR_DATA: prdata_reg <= {24'h00_0000, gpr[gpr_sel_reg]};
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Checking helpers: snapshot of each accepted command
  logic chk_go_reg;
  logic [31:0] chk_cmd_reg;
  logic [7:0] chk_rd_reg;
  logic [7:0] chk_rs_reg;
  logic [7:0] chk_flags_reg;
  logic [15:0] chk_ptr_reg;
  logic chk_mem_reg;
  bfls_op_type k_op;
  bfls_pmode_type k_mode;
  logic [4:0] k_dst;
  logic [2:0] k_bit;
  logic [1:0] k_ptr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chk_go_reg <= 1'b0;
      chk_cmd_reg <= 32'h0000_0000;
      chk_rd_reg <= 8'h00;
      chk_rs_reg <= 8'h00;
      chk_flags_reg <= 8'h00;
      chk_ptr_reg <= 16'h0000;
      chk_mem_reg <= 1'b0;
    end
    else
    begin
      chk_go_reg <= cmd_go;
      chk_cmd_reg <= pwdata;
      chk_rd_reg <= rd_v;
      chk_rs_reg <= rs_v;
      chk_flags_reg <= flags_reg;
      chk_ptr_reg <= ptr_cur;
      chk_mem_reg <= m_go;
    end
  end

  assign k_op = bfls_op_type'(chk_cmd_reg[F_OP_LSB +: F_OP_W]);
  assign k_mode = bfls_pmode_type'(chk_cmd_reg[F_MODE_LSB +: 2]);
  assign k_dst = chk_cmd_reg[F_DST_LSB +: 5];
  assign k_bit = chk_cmd_reg[F_BIT_LSB +: 3];
  assign k_ptr = chk_cmd_reg[F_PTR_LSB +: 2];

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_mem_issue;
    state_reg == BFLS_MEM && mem_addr_reg == $past(m_addr);
  endsequence

  sequence s_mem_done;
    state_reg == BFLS_IDLE;
  endsequence

  AST_ROTATE_RESULT: assert property ( // [RULE1]
    chk_go_reg && k_op == OP_ROTATE_RIGHT_CARRY |->
      gpr[k_dst] == {chk_flags_reg[FLAG_C], chk_rd_reg[7:1]}
      && flags_reg[FLAG_C] == chk_rd_reg[0] && flags_reg[FLAG_Z] == (gpr[k_dst] == 8'h00))
    else $error("rotate right result or carry wrong");

  AST_SHIFT_SIGN: assert property ( // [RULE2]
    chk_go_reg && k_op == OP_ARITH_SHIFT_RIGHT |->
      gpr[k_dst] == {chk_rd_reg[7], chk_rd_reg[7:1]} && flags_reg[FLAG_C] == chk_rd_reg[0]
      && flags_reg[FLAG_V] == (chk_rd_reg[7] ^ chk_rd_reg[0]))
    else $error("arithmetic shift result or flags wrong");

  AST_BIT_TO_T: assert property ( // [RULE3]
    chk_go_reg && k_op == OP_COPY_BIT_TO_TRANSFER_FLAG |->
      flags_reg[FLAG_T] == chk_rs_reg[k_bit]
      && (flags_reg | 8'h40) == (chk_flags_reg | 8'h40))
    else $error("bit copy to transfer flag wrong");

  AST_T_TO_BIT: assert property ( // [RULE4]
    chk_go_reg && k_op == OP_COPY_TRANSFER_FLAG_TO_BIT |->
      gpr[k_dst][k_bit] == chk_flags_reg[FLAG_T] && flags_reg == chk_flags_reg)
    else $error("transfer flag copy to bit wrong");

  AST_FLAG_SET_ONLY: assert property ( // [RULE5] [RULE7]
    chk_go_reg && k_op == OP_INDEXED_FLAG_SET |->
      flags_reg == (chk_flags_reg | (8'h01 << k_bit)))
    else $error("flag set touched wrong bits");

  AST_FLAG_CLEAR_ONLY: assert property ( // [RULE6] [RULE7]
    chk_go_reg && k_op == OP_INDEXED_FLAG_CLEAR |->
      flags_reg == (chk_flags_reg & ~(8'h01 << k_bit)))
    else $error("flag clear touched wrong bits");

  AST_SWAP_NIBBLES: assert property ( // [RULE14]
    chk_go_reg && k_op == OP_NIBBLE_SWAP |->
      gpr[k_dst] == {chk_rd_reg[3:0], chk_rd_reg[7:4]} && flags_reg == chk_flags_reg)
    else $error("nibble swap wrong");

  AST_MOVES_KEEP_FLAGS: assert property ( // [RULE15]
    chk_go_reg && (k_op == OP_REGISTER_COPY || k_op == OP_REGISTER_PAIR_COPY
      || k_op == OP_IMMEDIATE_LOAD) |->
      flags_reg == chk_flags_reg && state_reg == BFLS_IDLE)
    else $error("copy or immediate load changed flags or stalled");

  AST_MEM_TWO_CYCLES: assert property ( // [RULE11] [RULE16]
    m_go |=> s_mem_issue ##1 s_mem_done)
    else $error("memory operation not two cycles");

  AST_POST_INC: assert property ( // [RULE8] [RULE12]
    chk_mem_reg && k_mode == PM_POST_INC && k_op != OP_FETCH_POINTER_OFFSET
      && k_op != OP_FETCH_ABSOLUTE |->
      mem_addr_reg == chk_ptr_reg && ptr_pair(k_ptr) == chk_ptr_reg + 16'h0001)
    else $error("post-increment address or pointer wrong");

  AST_PRE_DEC: assert property ( // [RULE9] [RULE13]
    chk_mem_reg && k_mode == PM_PRE_DEC && k_op != OP_FETCH_POINTER_OFFSET
      && k_op != OP_FETCH_ABSOLUTE |->
      mem_addr_reg == chk_ptr_reg - 16'h0001 && ptr_pair(k_ptr) == mem_addr_reg)
    else $error("pre-decrement address or pointer wrong");

  AST_OFFSET_KEEPS_PTR: assert property ( // [RULE10]
    chk_mem_reg && k_op == OP_FETCH_POINTER_OFFSET |->
      ptr_pair(k_ptr) == chk_ptr_reg && k_ptr != PTR_X
      && mem_addr_reg == chk_ptr_reg + {10'h000, chk_cmd_reg[F_IMM_LSB +: DISP_W]})
    else $error("offset load address or pointer wrong");

  AST_LOAD_DATA: assert property ( // [RULE8] [RULE11]
    state_reg == BFLS_MEM && !mem_store_reg |=>
      gpr[$past(mem_dst_reg)] == $past(dmem.rdata) && flags_reg == $past(flags_reg))
    else $error("loaded byte not written to destination");

endmodule

`default_nettype wire

// ### sim/bfls_apb_master.sv
// APB master model for the execution unit's register port.
// Assumes a free-running pclk; every transfer waits a bounded time for pready.
`default_nettype none

module bfls_apb_master (
  // Clock
  input wire logic pclk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [bfls_pkg::APB_AW-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import bfls_pkg::*;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
  end

  // ==========================================================
  // One transfer: setup, access until pready, then release
  task automatic xfer(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err, output logic ok);
    int n;
    ok = 1'b0;
    rd = 32'h0;
    err = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 40 && !ok; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
      begin
        ok = 1'b1;
        rd = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
    // Released address and write data lines no longer show the old values
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
endmodule

`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the execution unit, driven over APB.
// Assumes the bfls_apb_master model and the command layout of the package.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bfls_pkg::*;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel;
  logic penable;
  logic pwrite;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rdat;
  logic rerr;
  int fail_count = 0;
  int samples_checked = 0;

  always #5 pclk = ~pclk;

  bfls_exec u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  bfls_apb_master u_mst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ==========================================================
  // Shared helpers
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic acc(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] wd);
    logic ok;
    u_mst.xfer(w, a, wd, rdat, rerr, ok);
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("mismatch pready expected 1 seen 0");
      stop_test();
    end
  endtask

  function automatic logic [31:0] cw(input logic [4:0] op, input logic [1:0] md,
    input logic [1:0] pt, input logic [4:0] d, input logic [4:0] s, input logic [2:0] b,
    input logic [7:0] k);
    return {2'h0, k, b, s, d, pt, md, op};
  endfunction

  task automatic ex(input logic [31:0] c);
    acc(1'b1, OFS_CMD, c);
  endtask

  task automatic pl(input logic [4:0] n, input logic [7:0] v);
    ex(cw(OP_IMMEDIATE_LOAD, PM_PLAIN, PTR_X, n, 5'h0, 3'h0, v));
  endtask

  task automatic gr(input logic [4:0] n, input string nm, input logic [7:0] e);
    acc(1'b1, OFS_GPR_SEL, {27'h0, n});
    acc(1'b0, OFS_GPR_DATA, 32'h0);
    chk(nm, {24'h0, e}, rdat);
  endtask

  task automatic fl(input logic [7:0] e);
    acc(1'b0, OFS_FLAGS, 32'h0);
    chk("flags", {24'h0, e}, rdat);
  endtask

  task automatic unary(input logic [4:0] op, input logic [2:0] b, input logic [7:0] fin,
    input logic [7:0] v, input logic [7:0] re, input logic [7:0] fe);
    acc(1'b1, OFS_FLAGS, {24'h0, fin});
    pl(5'h10, v);
    ex(cw(op, PM_PLAIN, PTR_X, 5'h10, 5'h10, b, 8'h0));
    gr(5'h10, "result", re);
    fl(fe);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    fl(8'h00);
    gr(5'h10, "r16", 8'h00);
    acc(1'b0, 8'h40, 32'h0);
    chk("unmapped data", 32'h0, rdat);
    chk("unmapped err", 32'h1, {31'h0, rerr});
  endtask

  task automatic t_shift();
    unary(OP_ROTATE_RIGHT_CARRY, 3'h0, 8'h71, 8'h02, 8'h81, 8'h7c);
    unary(OP_ROTATE_RIGHT_CARRY, 3'h0, 8'h00, 8'h01, 8'h00, 8'h0b);
    unary(OP_ARITH_SHIFT_RIGHT, 3'h0, 8'h00, 8'h81, 8'hc0, 8'h05);
    unary(OP_ARITH_SHIFT_RIGHT, 3'h0, 8'h80, 8'h01, 8'h00, 8'h8b);
  endtask

  task automatic t_bits();
    unary(OP_NIBBLE_SWAP, 3'h0, 8'ha5, 8'h3c, 8'hc3, 8'ha5);
    unary(OP_COPY_BIT_TO_TRANSFER_FLAG, 3'h5, 8'h00, 8'h20, 8'h20, 8'h40);
    unary(OP_COPY_BIT_TO_TRANSFER_FLAG, 3'h5, 8'hff, 8'hdf, 8'hdf, 8'hbf);
    unary(OP_COPY_TRANSFER_FLAG_TO_BIT, 3'h3, 8'h40, 8'h00, 8'h08, 8'h40);
    unary(OP_COPY_TRANSFER_FLAG_TO_BIT, 3'h7, 8'hbf, 8'hff, 8'h7f, 8'hbf);
  endtask

  task automatic t_flags();
    logic [7:0] m;
    pl(5'h10, 8'h96);
    for (int i = 0; i < 8; i++)
    begin
      m = 8'h01 << i;
      acc(1'b1, OFS_FLAGS, {24'h0, 8'h5a & ~m});
      ex(cw(OP_INDEXED_FLAG_SET, PM_PLAIN, PTR_X, 5'h0, 5'h0, 3'(i), 8'h0));
      fl(8'h5a | m);
      acc(1'b1, OFS_FLAGS, {24'h0, 8'ha5 | m});
      ex(cw(OP_INDEXED_FLAG_CLEAR, PM_PLAIN, PTR_X, 5'h0, 5'h0, 3'(i), 8'h0));
      fl(8'ha5 & ~m);
    end
    gr(5'h10, "r16", 8'h96);
  endtask

  task automatic t_move();
    acc(1'b1, OFS_FLAGS, 32'h96);
    pl(5'h14, 8'h5b);
    pl(5'h15, 8'hc4);
    ex(cw(OP_REGISTER_COPY, PM_PLAIN, PTR_X, 5'h11, 5'h14, 3'h0, 8'h0));
    gr(5'h11, "register copy", 8'h5b);
    ex(cw(OP_REGISTER_PAIR_COPY, PM_PLAIN, PTR_X, 5'h0c, 5'h14, 3'h0, 8'h0));
    gr(5'h0c, "pair copy low", 8'h5b);
    gr(5'h0d, "pair copy high", 8'hc4);
    fl(8'h96);
  endtask

  task automatic t_mem();
    acc(1'b1, OFS_FLAGS, 32'h33);
    pl(5'h1a, 8'h10);
    pl(5'h1b, 8'h00);
    pl(5'h01, 8'h3c);
    pl(5'h02, 8'ha7);
    pl(5'h08, 8'h5e);
    ex(cw(OP_WRITE_VIA_POINTER, PM_POST_INC, PTR_X, 5'h0, 5'h01, 3'h0, 8'h0));
    gr(PTR_X_LO, "x after store inc", 8'h11);
    ex(cw(OP_FETCH_VIA_POINTER, PM_PRE_DEC, PTR_X, 5'h03, 5'h0, 3'h0, 8'h0));
    gr(5'h03, "load dec data", 8'h3c);
    gr(PTR_X_LO, "x after load dec", 8'h10);
    ex(cw(OP_WRITE_VIA_POINTER, PM_PRE_DEC, PTR_X, 5'h0, 5'h02, 3'h0, 8'h0));
    gr(PTR_X_LO, "x after store dec", 8'h0f);
    ex(cw(OP_FETCH_VIA_POINTER, PM_PLAIN, PTR_X, 5'h04, 5'h0, 3'h0, 8'h0));
    gr(5'h04, "plain load data", 8'ha7);
    gr(PTR_X_LO, "x after plain load", 8'h0f);
    ex(cw(OP_FETCH_VIA_POINTER, PM_POST_INC, PTR_X, 5'h05, 5'h0, 3'h0, 8'h0));
    gr(5'h05, "load inc data", 8'ha7);
    gr(PTR_X_LO, "x after load inc", 8'h10);
    ex(cw(OP_WRITE_VIA_POINTER, PM_PLAIN, PTR_X, 5'h0, 5'h08, 3'h0, 8'h0));
    gr(PTR_X_LO, "x after plain store", 8'h10);
    pl(PTR_Z_LO, 8'h0a);
    pl(5'h1f, 8'h00);
    ex(cw(OP_FETCH_POINTER_OFFSET, PM_PLAIN, PTR_Z, 5'h06, 5'h0, 3'h0, 8'h06));
    gr(5'h06, "offset load data", 8'h5e);
    gr(PTR_Z_LO, "z after offset load", 8'h0a);
    ex(cw(OP_FETCH_POINTER_OFFSET, PM_PLAIN, PTR_X, 5'h09, 5'h0, 3'h0, 8'h00));
    gr(5'h09, "refused x offset load", 8'h00);
    acc(1'b1, OFS_ADDR_K, 32'h0f);
    ex(cw(OP_FETCH_ABSOLUTE, PM_PLAIN, PTR_X, 5'h07, 5'h0, 3'h0, 8'h0));
    gr(5'h07, "absolute load data", 8'ha7);
    fl(8'h33);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_shift();
    t_bits();
    t_flags();
    t_move();
    t_mem();
    stop_test();
  end
endmodule

`default_nettype wire
